// file: common/seq_pkg.sv
// constants, field layout and types for rail sequencing and group messaging
package seq_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // command codes of the two settings
   localparam logic [7:0]  ORDER_CODE      = 8'hE0;
   localparam logic [7:0]  GROUP_CODE      = 8'hE2;

   // rail order links fields
   localparam int          PRE_EN_BIT      = 15;
   localparam int          PRE_ID_LSB      = 8;
   localparam int          SUC_EN_BIT      = 7;
   localparam int          SUC_ID_LSB      = 0;
   localparam logic [15:0] ORDER_MASK      = 16'h9F9F;
   localparam logic [15:0] ORDER_RESET     = 16'h0000;

   // group membership fields
   localparam int          VOUT_EN_BIT     = 21;
   localparam int          VOUT_ID_LSB     = 16;
   localparam int          OPER_EN_BIT     = 13;
   localparam int          OPER_ID_LSB     = 8;
   localparam int          PFAIL_EN_BIT    = 5;
   localparam int          PFAIL_ID_LSB    = 0;
   localparam logic [31:0] GROUP_MASK      = 32'h003F3F3F;
   localparam logic [31:0] GROUP_RESET     = 32'h00000000;

   localparam int          ID_W            = 5;
   localparam int          EV_COUNT        = 6;

   ////////////////////////////////////////////////////////////////////////////
   // inter device bus event kinds
   typedef enum logic [2:0] {
      EV_POWER_GOOD  = 3'h0,
      EV_POWER_DOWN  = 3'h1,
      EV_VOUT_CMD    = 3'h2,
      EV_OPERATION   = 3'h3,
      EV_POWER_FAIL  = 3'h4,
      EV_SHARE_FAULT = 3'h5
   } ev_kind_e;

   // rail output state
   typedef enum logic [2:0] {
      ST_OFF      = 3'h0,
      ST_ON       = 3'h1,
      ST_WAIT_SUC = 3'h2,
      ST_DELAY    = 3'h3,
      ST_FAULT    = 3'h4
   } rail_state_e;

endpackage

// file: logic/off_delay_timer.sv
// programmable turn-off delay counter
`timescale 1ns/10ps
`default_nettype none
module off_delay_timer #(
   parameter int W = 16
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         start,
   input  wire logic [W-1:0] load,
   output logic              done
);

   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;
   logic         busy_r;
   logic         busy_nxt;
   logic         done_r;
   logic         done_nxt;

   // load on start, count down, pulse done after load+1 cycles
   always_comb begin
      cnt_nxt  = cnt_r;
      busy_nxt = busy_r;
      done_nxt = 1'b0;
      if (start) begin
         cnt_nxt  = load;
         busy_nxt = 1'b1;
      end else if (busy_r) begin
         if (cnt_r == '0) begin
            busy_nxt = 1'b0;
            done_nxt = 1'b1;
         end else begin
            cnt_nxt = cnt_r - 1'b1;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_r  <= '0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         busy_r <= busy_nxt;
         done_r <= done_nxt;
      end
   end

   assign done = done_r;

endmodule
`default_nettype wire

// file: logic/event_sender.sv
// holds pending outgoing events and presents one at a time
`timescale 1ns/10ps
`default_nettype none
module event_sender (
   input  wire logic                                       clk,
   input  wire logic                                       rst,
   input  wire logic [seq_pkg::EV_COUNT-1:0]               req,
   input  wire logic [seq_pkg::EV_COUNT*seq_pkg::ID_W-1:0] ids,
   input  wire logic                                       tx_ready,
   output logic                                            tx_valid,
   output logic [2:0]                                      tx_kind,
   output logic [seq_pkg::ID_W-1:0]                        tx_id
);

   logic [seq_pkg::EV_COUNT-1:0] pend_r;
   logic [seq_pkg::EV_COUNT-1:0] pend_nxt;
   logic                         valid_r;
   logic                         valid_nxt;
   logic [2:0]                   kind_r;
   logic [2:0]                   kind_nxt;
   logic [seq_pkg::ID_W-1:0]     id_r;
   logic [seq_pkg::ID_W-1:0]     id_nxt;

   // lowest kind first; a new request wins over the take
   always_comb begin
      logic found;
      found     = 1'b0;
      pend_nxt  = pend_r;
      valid_nxt = valid_r;
      kind_nxt  = kind_r;
      id_nxt    = id_r;
      if (valid_r && tx_ready) begin
         valid_nxt = 1'b0;
      end
      if (!valid_nxt) begin
         for (int k = 0; k < seq_pkg::EV_COUNT; k++) begin
            if (pend_r[k] && !found) begin
               found       = 1'b1;
               pend_nxt[k] = 1'b0;
               valid_nxt   = 1'b1;
               kind_nxt    = 3'(k);
               id_nxt      = ids[k*seq_pkg::ID_W +: seq_pkg::ID_W];
            end
         end
      end
      pend_nxt = pend_nxt | req;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pend_r  <= '0;
         valid_r <= 1'b0;
         kind_r  <= 3'h0;
         id_r    <= '0;
      end else begin
         pend_r  <= pend_nxt;
         valid_r <= valid_nxt;
         kind_r  <= kind_nxt;
         id_r    <= id_nxt;
      end
   end

   assign tx_valid = valid_r;
   assign tx_kind  = kind_r;
   assign tx_id    = id_r;

endmodule
`default_nettype wire

// file: logic/rail_sequencer.sv
// rail sequencing and group messaging for one converter rail
// Notes on behaviour
// - with a predecessor, turn on only after enable and its power-good event.
// - with a successor, turn off after its power-down event, then programmed delay.
// - order bit 15 enables predecessor, bits 12:8 hold its rail id.
// - order bit 7 enables successor, bits 4:0 hold its rail id.
// - order setting resets to zero, both relations disabled.
// - fault shutdown sends no power-down event to neighbours.
// - no automatic retry while in a fault or sequencing group.
// - group bit 21 enables response to matching output-voltage broadcasts.
// - group bits 20:16 are the id sent with output-voltage broadcasts.
// - group bit 13 enables response to matching operation broadcasts.
// - group bits 12:8 are the id sent with operation broadcasts.
// - group bit 5 enables response to matching power-fail events.
// - group bits 4:0 are the id sent with power-fail events.
// - current-sharing members spread faults among the rail regardless of group.
// - own events are sent even while incoming group messages are ignored.
`timescale 1ns/10ps
`default_nettype none
module rail_sequencer #(
   parameter int DELAY_W = 16
) (
   input  wire logic                       clk,
   input  wire logic                       rst,
   input  wire logic [7:0]                 cfg_code,
   input  wire logic                       cfg_wr,
   input  wire logic                       cfg_rd,
   input  wire logic [31:0]                cfg_wdata,
   output logic [31:0]                     cfg_rdata,
   output logic                            cfg_ack,
   input  wire logic [seq_pkg::ID_W-1:0]   rail_id,
   input  wire logic                       share_member,
   input  wire logic                       retry_cfg,
   input  wire logic                       en_request,
   input  wire logic                       pg_in,
   input  wire logic                       zero_reached,
   input  wire logic                       fault_in,
   input  wire logic                       fault_clear,
   input  wire logic [DELAY_W-1:0]         off_delay,
   input  wire logic                       local_vout_bcast,
   input  wire logic                       local_op_bcast,
   input  wire logic                       rx_valid,
   input  wire logic [2:0]                 rx_kind,
   input  wire logic [seq_pkg::ID_W-1:0]   rx_id,
   input  wire logic                       rx_op_on,
   output logic                            tx_valid,
   output logic [2:0]                      tx_kind,
   output logic [seq_pkg::ID_W-1:0]        tx_id,
   input  wire logic                       tx_ready,
   output logic                            out_on,
   output logic                            fault_shut,
   output logic                            retry_permit,
   output logic                            vout_apply,
   output logic                            op_apply,
   output logic                            op_on
);

   // true when a received event has the given kind and id
   function automatic logic ev_hit(input logic v, input logic [2:0] k, input logic [4:0] i,
                                   input seq_pkg::ev_kind_e want, input logic [4:0] id);
      return v && (k == want) && (i == id);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // settings registers
   logic [15:0] order_r, order_nxt;
   logic [31:0] group_r, group_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic        ack_r, ack_nxt;

   // writes keep only used bits, reads return zero in unused ones
   always_comb begin
      order_nxt = order_r;
      group_nxt = group_r;
      rdata_nxt = rdata_r;
      ack_nxt   = 1'b0;
      if (cfg_wr && cfg_code == seq_pkg::ORDER_CODE) begin
         order_nxt = cfg_wdata[15:0] & seq_pkg::ORDER_MASK;
         ack_nxt   = 1'b1;
      end else if (cfg_wr && cfg_code == seq_pkg::GROUP_CODE) begin
         group_nxt = cfg_wdata & seq_pkg::GROUP_MASK;
         ack_nxt   = 1'b1;
      end else if (cfg_rd && cfg_code == seq_pkg::ORDER_CODE) begin
         rdata_nxt = {16'h0000, order_r};
         ack_nxt   = 1'b1;
      end else if (cfg_rd && cfg_code == seq_pkg::GROUP_CODE) begin
         rdata_nxt = group_r;
         ack_nxt   = 1'b1;
      end else if (cfg_rd) begin
         rdata_nxt = 32'h00000000;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         order_r <= seq_pkg::ORDER_RESET;
         group_r <= seq_pkg::GROUP_RESET;
         rdata_r <= 32'h00000000;
         ack_r   <= 1'b0;
      end else begin
         order_r <= order_nxt;
         group_r <= group_nxt;
         rdata_r <= rdata_nxt;
         ack_r   <= ack_nxt;
      end
   end

   assign cfg_rdata = rdata_r;
   assign cfg_ack   = ack_r;

   ////////////////////////////////////////////////////////////////////////////
   // field decode
   logic       pre_en, suc_en, vout_en, oper_en, pfail_en;
   logic [4:0] pre_id, suc_id, vout_gid, oper_gid, pfail_gid;

   // relations and group ids
   assign pre_en    = order_r[seq_pkg::PRE_EN_BIT];
   assign pre_id    = order_r[seq_pkg::PRE_ID_LSB +: seq_pkg::ID_W];
   assign suc_en    = order_r[seq_pkg::SUC_EN_BIT];
   assign suc_id    = order_r[seq_pkg::SUC_ID_LSB +: seq_pkg::ID_W];
   assign vout_en   = group_r[seq_pkg::VOUT_EN_BIT];
   assign vout_gid  = group_r[seq_pkg::VOUT_ID_LSB +: seq_pkg::ID_W];
   assign oper_en   = group_r[seq_pkg::OPER_EN_BIT];
   assign oper_gid  = group_r[seq_pkg::OPER_ID_LSB +: seq_pkg::ID_W];
   assign pfail_en  = group_r[seq_pkg::PFAIL_EN_BIT];
   assign pfail_gid = group_r[seq_pkg::PFAIL_ID_LSB +: seq_pkg::ID_W];

   ////////////////////////////////////////////////////////////////////////////
   // incoming event decode
   logic pre_good_ev, pre_down_ev, suc_down_ev, vout_hit, oper_hit, pfail_hit, share_hit;

   // group responses gated by their enable bits
   assign pre_good_ev = ev_hit(rx_valid, rx_kind, rx_id, seq_pkg::EV_POWER_GOOD, pre_id);
   assign pre_down_ev = ev_hit(rx_valid, rx_kind, rx_id, seq_pkg::EV_POWER_DOWN, pre_id);
   assign suc_down_ev = ev_hit(rx_valid, rx_kind, rx_id, seq_pkg::EV_POWER_DOWN, suc_id);
   assign vout_hit    = vout_en && ev_hit(rx_valid, rx_kind, rx_id, seq_pkg::EV_VOUT_CMD, vout_gid);
   assign oper_hit    = oper_en && ev_hit(rx_valid, rx_kind, rx_id, seq_pkg::EV_OPERATION, oper_gid);
   assign pfail_hit   = pfail_en && ev_hit(rx_valid, rx_kind, rx_id, seq_pkg::EV_POWER_FAIL, pfail_gid);
   assign share_hit   = share_member && ev_hit(rx_valid, rx_kind, rx_id, seq_pkg::EV_SHARE_FAULT, rail_id);

   ////////////////////////////////////////////////////////////////////////////
   // rail state machine and event latches
   seq_pkg::rail_state_e state_r, state_nxt;
   logic                 pre_good_r, pre_good_nxt;
   logic                 suc_down_r, suc_down_nxt;
   logic                 pg_d_r, zero_d_r;
   logic                 delay_start, delay_done, fault_any;

   assign fault_any = fault_in || pfail_hit || share_hit;

   // sequencing decisions; a latch set wins over its clear
   always_comb begin
      state_nxt    = state_r;
      delay_start  = 1'b0;
      pre_good_nxt = pre_good_r;
      suc_down_nxt = suc_down_r;
      if (pre_down_ev) begin
         pre_good_nxt = 1'b0;
      end
      if (pre_good_ev) begin
         pre_good_nxt = 1'b1;
      end
      if (state_r == seq_pkg::ST_ON) begin
         suc_down_nxt = 1'b0;
      end
      if (suc_down_ev) begin
         suc_down_nxt = 1'b1;
      end
      if (fault_any) begin
         state_nxt = seq_pkg::ST_FAULT;
      end else begin
         unique case (state_r)
            seq_pkg::ST_OFF: begin
               if (en_request && (!pre_en || pre_good_r)) begin
                  state_nxt = seq_pkg::ST_ON;
               end
            end
            seq_pkg::ST_ON: begin
               if (!en_request) begin
                  state_nxt = seq_pkg::ST_WAIT_SUC;
               end
            end
            seq_pkg::ST_WAIT_SUC: begin
               if (en_request) begin
                  state_nxt = seq_pkg::ST_ON;
               end else if (!suc_en || suc_down_r) begin
                  state_nxt   = seq_pkg::ST_DELAY;
                  delay_start = 1'b1;
               end
            end
            seq_pkg::ST_DELAY: begin
               if (delay_done) begin
                  state_nxt = seq_pkg::ST_OFF;
               end
            end
            seq_pkg::ST_FAULT: begin
               if (fault_clear && !fault_in) begin
                  state_nxt = seq_pkg::ST_OFF;
               end
            end
            default: state_nxt = seq_pkg::ST_OFF;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r    <= seq_pkg::ST_OFF;
         pre_good_r <= 1'b0;
         suc_down_r <= 1'b0;
         pg_d_r     <= 1'b0;
         zero_d_r   <= 1'b0;
      end else begin
         state_r    <= state_nxt;
         pre_good_r <= pre_good_nxt;
         suc_down_r <= suc_down_nxt;
         pg_d_r     <= pg_in;
         zero_d_r   <= zero_reached;
      end
   end

   off_delay_timer #(.W(DELAY_W)) u_delay (
      .clk   (clk),
      .rst   (rst),
      .start (delay_start),
      .load  (off_delay),
      .done  (delay_done)
   );

   ////////////////////////////////////////////////////////////////////////////
   // rail outputs and group command pulses
   logic out_on_r, vout_apply_r, op_apply_r;
   logic op_on_r, op_on_nxt;

   assign op_on_nxt = oper_hit ? rx_op_on : op_on_r;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         out_on_r     <= 1'b0;
         vout_apply_r <= 1'b0;
         op_apply_r   <= 1'b0;
         op_on_r      <= 1'b0;
      end else begin
         out_on_r     <= (state_nxt == seq_pkg::ST_ON) || (state_nxt == seq_pkg::ST_WAIT_SUC) ||
                         (state_nxt == seq_pkg::ST_DELAY);
         vout_apply_r <= vout_hit;
         op_apply_r   <= oper_hit;
         op_on_r      <= op_on_nxt;
      end
   end

   assign out_on       = out_on_r;
   assign fault_shut   = (state_r == seq_pkg::ST_FAULT);
   assign vout_apply   = vout_apply_r;
   assign op_apply     = op_apply_r;
   assign op_on        = op_on_r;
   assign retry_permit = retry_cfg && !pfail_en && !pre_en && !suc_en;

   ////////////////////////////////////////////////////////////////////////////
   // outgoing events, sent whatever the response enables are
   logic [seq_pkg::EV_COUNT-1:0]               tx_req;
   logic [seq_pkg::EV_COUNT*seq_pkg::ID_W-1:0] tx_ids;
   logic                                       fault_entry;

   assign fault_entry = fault_any && state_r != seq_pkg::ST_FAULT;

   // power-down only on an orderly ramp to zero, never after a fault
   assign tx_req[0] = pg_in && !pg_d_r;
   assign tx_req[1] = zero_reached && !zero_d_r && state_r != seq_pkg::ST_FAULT && !fault_any;
   assign tx_req[2] = local_vout_bcast;
   assign tx_req[3] = local_op_bcast;
   assign tx_req[4] = fault_entry && fault_in;
   assign tx_req[5] = fault_entry && fault_in && share_member;
   assign tx_ids    = {rail_id, pfail_gid, oper_gid, vout_gid, rail_id, rail_id};

   event_sender u_sender (
      .clk      (clk),
      .rst      (rst),
      .req      (tx_req),
      .ids      (tx_ids),
      .tx_ready (tx_ready),
      .tx_valid (tx_valid),
      .tx_kind  (tx_kind),
      .tx_id    (tx_id)
   );

   ////////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_pre_ready;
      en_request && pre_en && pre_good_r && state_r == seq_pkg::ST_OFF && !fault_any;
   endsequence

   sequence s_turn_on;
      ##1 out_on;
   endsequence

   order_write_mask_a: assert property (@(posedge clk) disable iff (rst)
      cfg_wr && cfg_code == seq_pkg::ORDER_CODE |=> (order_r & ~seq_pkg::ORDER_MASK) == 16'h0000 &&
      order_r == ($past(cfg_wdata[15:0]) & seq_pkg::ORDER_MASK))
      else $error("order setting write not masked");
   group_write_mask_a: assert property (@(posedge clk) disable iff (rst)
      cfg_wr && cfg_code == seq_pkg::GROUP_CODE |=> group_r == ($past(cfg_wdata) & seq_pkg::GROUP_MASK))
      else $error("group setting write not masked");
   pre_gate_on_a: assert property (@(posedge clk) disable iff (rst)
      state_r == seq_pkg::ST_OFF && pre_en && !pre_good_r |=> !out_on)
      else $error("rail on without predecessor power good");
   pre_ready_on_a: assert property (@(posedge clk) disable iff (rst)
      s_pre_ready |-> s_turn_on)
      else $error("rail did not turn on after predecessor power good");
   suc_gate_off_a: assert property (@(posedge clk) disable iff (rst)
      state_r == seq_pkg::ST_WAIT_SUC && suc_en && !suc_down_r && !fault_any |=> out_on)
      else $error("rail off before successor power down");
   fault_no_down_a: assert property (@(posedge clk) disable iff (rst)
      state_r == seq_pkg::ST_FAULT |-> !tx_req[1])
      else $error("power down sent after fault");
   retry_block_a: assert property (@(posedge clk) disable iff (rst)
      (pfail_en || pre_en || suc_en) |-> !retry_permit)
      else $error("retry allowed inside a group");
   vout_ignore_a: assert property (@(posedge clk) disable iff (rst)
      rx_valid && rx_kind == seq_pkg::EV_VOUT_CMD && !vout_en |=> !vout_apply)
      else $error("vout broadcast acted on while disabled");
   pfail_resp_a: assert property (@(posedge clk) disable iff (rst)
      pfail_hit |=> fault_shut && !out_on)
      else $error("power fail event not obeyed");
   share_spread_a: assert property (@(posedge clk) disable iff (rst)
      share_hit |=> fault_shut)
      else $error("share fault not spread");

endmodule
`default_nettype wire

// file: verification/peer_converter.sv
// peer converter on the inter-device bus
`timescale 1ns/10ps
`default_nettype none
module peer_converter (
   input  wire logic       clk,
   input  wire logic       rst,
   output logic            rx_valid,
   output logic [2:0]      rx_kind,
   output logic [4:0]      rx_id,
   output logic            rx_op_on,
   output logic            tx_ready
);
   logic [1:0] pace_r;
   initial begin
      rx_valid = 0;
      rx_kind = 3'h7;
      rx_id = 5'h1F;
      rx_op_on = 0;
   end
   // accepts two cycles of four, so the sender sees stalls
   always @(posedge clk or posedge rst)
      if (rst) pace_r <= 2'h0;
      else pace_r <= pace_r + 2'h1;
   assign tx_ready = pace_r[1];
   // one event per taking edge, then scrambled lines
   task automatic send(input logic [2:0] k, input logic [4:0] id, input logic on);
      @(posedge clk);
      #1 rx_kind = k;
      rx_id = id;
      rx_op_on = on;
      rx_valid = 1;
      @(posedge clk);
      #1 rx_valid = 0;
      rx_kind = ~k;
      rx_id = ~id;
      rx_op_on = ~on;
   endtask
endmodule
`default_nettype wire

// file: verification/testbench.sv
// self-checking bench for the rail sequencer
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic        clk = 0, rst = 1, cfg_wr = 0, cfg_rd = 0, rd_seen = 0;
   logic        en_request = 0, pg_in = 0, zero_reached = 0, fault_in = 0;
   logic        fault_clear = 0, local_vout_bcast = 0, local_op_bcast = 0;
   logic        share_member = 0, retry_cfg = 1, cfg_ack, rx_valid, rx_op_on;
   logic        tx_valid, tx_ready, out_on, fault_shut, retry_permit;
   logic        vout_apply, op_apply, op_on;
   logic [7:0]  cfg_code = 8'h00;
   logic [31:0] cfg_wdata = 32'h0, cfg_rdata, v;
   logic [4:0]  rail_id = 5'h03, rx_id, tx_id;
   logic [2:0]  rx_kind, tx_kind;
   logic [15:0] off_delay = 16'h0003;
   integer      seed = 32'h3B12;
   int          fails = 0, total_checks = 0, cyc = 0;
   logic [31:0] rdq[$];
   logic [7:0]  txq[$];
   rail_sequencer #(.DELAY_W(16)) i_dut (
      .clk, .rst, .cfg_code, .cfg_wr, .cfg_rd, .cfg_wdata, .cfg_rdata, .cfg_ack, .rail_id, .share_member,
      .retry_cfg, .en_request, .pg_in, .zero_reached, .fault_in, .fault_clear, .off_delay,
      .local_vout_bcast, .local_op_bcast, .rx_valid, .rx_kind, .rx_id, .rx_op_on, .tx_valid, .tx_kind,
      .tx_id, .tx_ready, .out_on, .fault_shut, .retry_permit, .vout_apply, .op_apply, .op_on);
   peer_converter i_peer (.clk, .rst, .rx_valid, .rx_kind, .rx_id, .rx_op_on, .tx_ready);
   initial forever #5 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic acc(input logic [7:0] c, input logic w, input logic [31:0] d);
      @(posedge clk);
      #1 cfg_code = c;
      cfg_wr = w;
      cfg_rd = !w;
      cfg_wdata = d;
      @(posedge clk);
      #1 cfg_wr = 0;
      cfg_rd = 0;
   endtask
   task automatic rd(input logic [7:0] c, input logic [31:0] e);
      rdq.push_back(e);
      acc(c, 0, 32'h0);
   endtask
   task automatic drain();
      while (txq.size() != 0) @(posedge clk);
      #1;
   endtask
   task automatic wrap_up();
      chk(rdq.size() + txq.size(), 0, "notes left");
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // watcher: oldest note against each read answer and sent event
   always @(posedge clk) rd_seen <= cfg_rd;
   always @(negedge clk) begin
      if (rd_seen && cfg_ack) chk(cfg_rdata, rdq.pop_front(), "read");
      if (tx_valid && tx_ready) chk({tx_kind, tx_id}, txq.pop_front(), "event");
   end
   // hang limit
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fails = fails + 1;
         wrap_up();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge clk);
      #1 rst = 0;
      rd(8'hE0, 32'h0);
      rd(8'hE2, 32'h0);
      chk(retry_permit, 1, "retry free");
      for (int i = 0; i < 4; i++) begin
         v = $random(seed);
         acc(8'hE2, 1, v);
         rd(8'hE2, v & 32'h003F3F3F);
      end
      acc(8'hE0, 1, 32'hFFFFFFFF);
      rd(8'hE0, 32'h00009F9F);
      acc(8'hE5, 0, 32'h0);
      chk(cfg_rdata, 0, "unmapped");
      chk(retry_permit, 0, "retry barred");
      $display("test registers done");
      for (int j = 0; j < 2; j++) begin
         acc(8'hE2, 1, j ? 32'h00050607 : 32'h00252627);
         for (int i = 0; i < 4; i++) begin
            i_peer.send(i[0] ? 3'h3 : 3'h2, i[1] ? 5'h09 : 5'h05 + 5'(i[0]), 1'b1);
            chk({vout_apply, op_apply}, (j | i[1]) ? 0 : (i[0] ? 1 : 2), "apply");
         end
         txq.push_back(8'h45);
         txq.push_back(8'h66);
         local_vout_bcast = 1;
         local_op_bcast = 1;
         @(posedge clk);
         #1 local_vout_bcast = 0;
         local_op_bcast = 0;
         drain();
      end
      chk(op_on, 1, "operation on");
      $display("test groups done");
      acc(8'hE0, 1, 32'h00008900);
      en_request = 1;
      i_peer.send(3'h0, 5'h0A, 1'b0);
      repeat (4) @(posedge clk);
      #1 chk(out_on, 0, "held off");
      i_peer.send(3'h0, 5'h09, 1'b0);
      repeat (3) @(posedge clk);
      #1 chk(out_on, 1, "turned on");
      txq.push_back(8'h03);
      pg_in = 1;
      drain();
      txq.push_back(8'h87);
      fault_in = 1;
      drain();
      zero_reached = 1;
      repeat (6) @(posedge clk);
      #1 chk({fault_shut, out_on}, 2, "fault off");
      // clear the fault, then an orderly turn-off behind a successor
      fault_in = 0;
      fault_clear = 1;
      zero_reached = 0;
      acc(8'hE0, 1, 32'h0000008C);
      repeat (2) @(posedge clk);
      #1 fault_clear = 0;
      chk(out_on, 1, "on after clear");
      en_request = 0;
      i_peer.send(3'h1, 5'h0A, 1'b0);
      repeat (3) @(posedge clk);
      #1 chk(out_on, 1, "waits for successor");
      i_peer.send(3'h1, 5'h0C, 1'b0);
      repeat (off_delay + 2) @(posedge clk);
      #1 chk(out_on, 1, "delay running");
      @(posedge clk);
      #1 chk(out_on, 0, "turned off");
      txq.push_back(8'h23);
      zero_reached = 1;
      drain();
      // spread faults from a power-fail group and from the sharing rail
      acc(8'hE2, 1, 32'h00000027);
      en_request = 1;
      repeat (2) @(posedge clk);
      #1 chk(out_on, 1, "on again");
      i_peer.send(3'h4, 5'h07, 1'b0);
      chk({fault_shut, out_on}, 2, "power fail");
      fault_clear = 1;
      share_member = 1;
      repeat (3) @(posedge clk);
      #1 fault_clear = 0;
      i_peer.send(3'h5, 5'h03, 1'b0);
      chk(fault_shut, 1, "share spread");
      $display("test sequencing done");
      wrap_up();
   end
endmodule
`default_nettype wire
